// >>> rtl/alu_acc_pkg.sv
// package for the lookahead alu / accumulator datapath
// assumes one 100 MHz clock and an apb master in the surrounding system
package alu_acc_pkg;
	localparam int SLICE_W   = 4;        // bits per alu slice
	localparam int BLOCK_W   = 16;       // bits under one lookahead generator
	localparam int GROUP_N   = 4;        // slices per lookahead generator
	localparam int WORD_W    = 32;       // default operand width
	localparam int ACC_SLICES = 2;       // cascaded accumulator slices
	localparam int ACC_W     = ACC_SLICES * SLICE_W;

	// register byte offsets
	localparam logic [7:0] OFS_OPA    = 8'h00;  // operand a
	localparam logic [7:0] OFS_OPB    = 8'h04;  // operand b
	localparam logic [7:0] OFS_CTRL   = 8'h08;  // function select, mode, cin
	localparam logic [7:0] OFS_RESULT = 8'h0C;  // function result
	localparam logic [7:0] OFS_FLAGS  = 8'h10;  // equality and carry flags
	localparam logic [7:0] OFS_ACC    = 8'h14;  // accumulator control/state

	// control field positions
	localparam int CTRL_SEL_LSB = 0;   // 4-bit function select
	localparam int CTRL_ARITH   = 4;   // 1 = arithmetic, 0 = logic
	localparam int CTRL_CIN     = 5;   // carry in, active high
	localparam int CTRL_ADDPASS = 6;   // add-or-pass shortcut select
	localparam int CTRL_RIPPLE  = 7;   // 1 = plain ripple between slices
	localparam int ACC_MODE_LSB = 0;   // 2-bit accumulator mode
	localparam int ACC_CPL      = 2;   // ones-complement control
	localparam int ACC_ROT      = 3;   // rotate instead of shift
	localparam int ACC_SRC      = 4;   // load source: 1 = alu result

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {ACC_HOLD, ACC_LEFT, ACC_RIGHT, ACC_LOAD} acc_mode_t;

	// per-slice group terms
	typedef struct packed {
		logic g;
		logic p;
	} gp_t;

	// alu function control
	typedef struct packed {
		logic       ripple;
		logic       arith;
		logic       cin;
		logic [3:0] sel;
	} alu_ctl_t;
endpackage

// >>> rtl/alu_accumulator.sv
// top: apb-reached lookahead alu datapath feeding a cascaded shift/load accumulator
// assumes an apb master on pclk; only the accumulator and registers hold state
`timescale 1ns/1ps
module alu_accumulator
	import alu_acc_pkg::*;
#(
	parameter int WIDTH = alu_acc_pkg::WORD_W   // operand width, multiple of four
)
(
	input  wire logic        pclk,                 // apb clock
	input  wire logic        presetn,              // apb reset, active low
	input  wire logic        psel,                 // apb select
	input  wire logic        penable,              // apb enable
	input  wire logic        pwrite,               // apb direction
	input  wire logic [7:0]  paddr,                // apb byte address
	input  wire logic [31:0] pwdata,               // apb write data
	output logic [31:0]      prdata,               // apb read data
	output logic             pready,               // apb ready
	output logic             pslverr,              // apb error
	input  wire logic        accumulator_clear_n,  // async accumulator clear
	input  wire logic        shift_in_right,       // serial in for right shift
	input  wire logic        shift_in_left,        // serial in for left shift
	output logic [ACC_W-1:0] acc_q,                // accumulator outputs
	output logic             equal_flag,           // result all ones
	output logic             carry_flag            // inverted word carry out
);
	import alu_acc_pkg::*;

	localparam int SLICES = WIDTH / SLICE_W;
	localparam int BLOCKS = (SLICES + GROUP_N - 1) / GROUP_N;

	// software-visible state
	logic [WIDTH-1:0] opa_r;   // operand a
	logic [WIDTH-1:0] opb_r;   // operand b
	logic [7:0]       ctrl_r;  // alu control
	logic [4:0]       accc_r;  // accumulator control
	logic [ACC_W-1:0] acc_r;   // accumulator
	logic [ACC_W-1:0] acc_nxt; // accumulator next value

	// apb decode
	wire wr_en   = psel & penable & pwrite;
	wire hit_a   = (paddr == OFS_OPA);
	wire hit_b   = (paddr == OFS_OPB);
	wire hit_c   = (paddr == OFS_CTRL);
	wire hit_r   = (paddr == OFS_RESULT);
	wire hit_f   = (paddr == OFS_FLAGS);
	wire hit_acc = (paddr == OFS_ACC);
	wire mapped  = hit_a | hit_b | hit_c | hit_r | hit_f | hit_acc;

	// add-or-pass: one control bit drives select bits zero and three, one and two low
	wire       addpass = ctrl_r[CTRL_ADDPASS];
	wire [3:0] sel_eff = addpass ? {ctrl_r[CTRL_ARITH], 2'b00, ctrl_r[CTRL_ARITH]}
		: ctrl_r[CTRL_SEL_LSB +: 4];
	wire       arith_eff = addpass ? 1'b1 : ctrl_r[CTRL_ARITH];
	wire       ripple    = ctrl_r[CTRL_RIPPLE];
	wire       cin       = ctrl_r[CTRL_CIN];

	// slice wiring
	logic [WIDTH-1:0]  fres;               // word result
	logic [SLICES:0]   cs;                 // carry into each slice
	logic [SLICES-1:0] co;                 // slice carry outs
	gp_t  [SLICES-1:0] gps;                // slice group terms
	logic [BLOCKS:0]   cb;                 // carry into each block
	logic [SLICES-1:0] cla_c;              // lookahead carry into each slice

	genvar s;
	generate
		for (s = 0; s < SLICES; s++)
		begin : g_slice
			alu_slice u_slice (
				.a               (opa_r[s*SLICE_W +: SLICE_W]),
				.b               (opb_r[s*SLICE_W +: SLICE_W]),
				.sel             (sel_eff),
				.arith           (arith_eff),
				.cin             (cs[s]),
				.f               (fres[s*SLICE_W +: SLICE_W]),
				.slice_carry_out (co[s]),
				.gp              (gps[s])
			);
			// ripple mode takes the neighbour's carry with no extra logic
			if (s == 0)
			begin : g_first
				assign cs[s] = cla_c[s];
			end
			else
			begin : g_next
				assign cs[s] = ripple ? co[s-1] : cla_c[s];
			end
		end
	endgenerate

	// one generator per full sixteen-bit block; a short top block ripples
	genvar k;
	generate
		for (k = 0; k < BLOCKS; k++)
		begin : g_block
			localparam int FIRST = k * GROUP_N;
			localparam int LEFT  = SLICES - FIRST;
			assign cla_c[FIRST] = cb[k];
			if (LEFT >= GROUP_N)
			begin : g_full
				logic [2:0] mid;
				gp_t        grp;
				lookahead_gen u_cla (
					.gp_in     (gps[FIRST +: GROUP_N]),
					.cin       (cb[k]),
					.carry_mid (mid),
					.gp_out    (grp)
				);
				assign cla_c[FIRST+1] = mid[0];
				assign cla_c[FIRST+2] = mid[1];
				assign cla_c[FIRST+3] = mid[2];
				// block carry ripples to the next block, no third level
				assign cb[k+1] = grp.g | (grp.p & cb[k]);
			end
			else
			begin : g_tail
				// four/eight/twelve bit tails: carry ripples through the extra slices
				for (genvar t = 1; t < LEFT; t++)
				begin : g_rip
					assign cla_c[FIRST+t] = co[FIRST+t-1];
				end
				assign cb[k+1] = co[SLICES-1];
			end
		end
	endgenerate
	assign cb[0]      = cin;
	// word carry: top block's lookahead carry, or the last slice when rippling
	assign cs[SLICES] = ripple ? co[SLICES-1] : cb[BLOCKS];

	// flags: all ones means pass zero, equivalence identical, xor complementary
	assign equal_flag = &fres;
	// under a minus b, high means a below b; under a minus b minus 1, a at most b
	// active-high operands: the pin shows the inverted carry, so high is a borrow
	assign carry_flag = ~cs[SLICES];

	// accumulator operand, optional ones complement by xor; a load uses the
	// control word being written, so mode, source and complement land together
	wire             acc_wr  = wr_en & hit_acc;
	wire [4:0]       ctl_w   = pwdata[ACC_SRC:0];
	wire             ld_req  = acc_wr & (ctl_w[ACC_MODE_LSB +: 2] == 2'b11);
	wire [ACC_W-1:0] acc_src = ctl_w[ACC_SRC] ? fres[ACC_W-1:0] : pwdata[ACC_W-1:0];
	wire [ACC_W-1:0] acc_opd = acc_src ^ {ACC_W{ctl_w[ACC_CPL]}};
	wire             rot     = accc_r[ACC_ROT];
	wire [1:0]       mode    = accc_r[ACC_MODE_LSB +: 2];

	// cascade: each slice's inner serial input comes from its neighbour's output, the outer ones from the pins or the far end
	wire sin_r = rot ? acc_r[0] : shift_in_right;
	wire sin_l = rot ? acc_r[ACC_W-1] : shift_in_left;
	wire [ACC_W-1:0] shl = {acc_r[ACC_W-2:0], sin_l};
	wire [ACC_W-1:0] shr = {sin_r, acc_r[ACC_W-1:1]};

	// mode decode; the edge of an acc control write only loads or holds
	always_comb
	begin
		acc_nxt = acc_r;
		if (acc_wr)
			acc_nxt = ld_req ? acc_opd : acc_r;
		else
		begin
			unique case (acc_mode_t'(mode))
				ACC_HOLD:  acc_nxt = acc_r;
				ACC_LEFT:  acc_nxt = shl;
				ACC_RIGHT: acc_nxt = shr;
				ACC_LOAD:  acc_nxt = acc_r;  // load waits for a write
			endcase
		end
	end

	// the accumulator is the only datapath state
	always_ff @(posedge pclk or negedge accumulator_clear_n)
	begin
		if (!accumulator_clear_n)
			acc_r <= '0;
		else
			acc_r <= acc_nxt;
	end
	assign acc_q = acc_r;

	// register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			opa_r  <= '0;
			opb_r  <= '0;
			ctrl_r <= CTRL_RESET[7:0];
			accc_r <= '0;
		end
		else if (wr_en)
		begin
			if (hit_a)
				opa_r <= pwdata[WIDTH-1:0];
			if (hit_b)
				opb_r <= pwdata[WIDTH-1:0];
			if (hit_c)
				ctrl_r <= pwdata[7:0];
			if (hit_acc)
				accc_r <= pwdata[ACC_SRC:0];
		end
	end

	// read mux, registered so data comes from flip-flops
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit_a)
			rd_mux[WIDTH-1:0] = opa_r;
		else if (hit_b)
			rd_mux[WIDTH-1:0] = opb_r;
		else if (hit_c)
			rd_mux[7:0] = ctrl_r;
		else if (hit_r)
			rd_mux[WIDTH-1:0] = fres;
		else if (hit_f)
			rd_mux[1:0] = {carry_flag, equal_flag};
		else if (hit_acc)
			rd_mux = {16'h0000, acc_r, 3'h0, accc_r};
	end

	// answer takes one access cycle: ready raises on the first penable cycle's edge
	logic rdy_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			rdy_r  <= 1'b0;
		end
		else
		begin
			rdy_r <= psel & ~penable;
			if (psel & ~penable)
				prdata <= rd_mux;
		end
	end
	assign pready  = rdy_r & psel & penable;
	assign pslverr = pready & ~mapped;
endmodule

// >>> rtl/alu_slice.sv
// one 4-bit alu slice with group generate/propagate outputs
// assumes active-high data; combinational only
`timescale 1ns/1ps
module alu_slice
	import alu_acc_pkg::*;
(
	input  wire logic [3:0]       a,          // operand a
	input  wire logic [3:0]       b,          // operand b
	input  wire logic [3:0]       sel,        // function select
	input  wire logic             arith,      // 1 = arithmetic
	input  wire logic             cin,        // carry in, active high
	output logic [3:0]            f,          // function result
	output logic                  slice_carry_out, // carry out, active high
	output alu_acc_pkg::gp_t      gp          // group terms
);
	logic [3:0] lg;   // logic function per bit
	logic [3:0] ta;   // first arithmetic term
	logic [3:0] tb;   // second arithmetic term
	logic [3:0] gb;   // bit generate
	logic [3:0] pb;   // bit propagate
	logic [4:0] c;    // internal carries

	// per-bit decode; the select bits pick the minterms of a and b
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			lg[i] = ~(a[i] | (b[i] & sel[0]) | (~b[i] & sel[1]))
				^ ((a[i] & ~b[i] & sel[2]) | (a[i] & b[i] & sel[3]));
			ta[i] = a[i] | (b[i] & sel[0]) | (~b[i] & sel[1]);
			tb[i] = (a[i] & ~b[i] & sel[2]) | (a[i] & b[i] & sel[3]);
			gb[i] = tb[i];
			pb[i] = ta[i];
		end
	end

	// sum = ta plus tb plus cin, formed from generate/propagate
	always_comb
	begin
		c[0] = cin;
		for (int i = 0; i < 4; i++)
			c[i + 1] = gb[i] | (pb[i] & c[i]);
	end

	// sum bit: both terms and the incoming carry, true sense for active-high data
	assign f               = arith ? (ta ^ tb ^ c[3:0]) : lg;
	assign slice_carry_out = c[4];
	// the same pair is fed upward whatever the data polarity, only its sense differs
	assign gp.g = gb[3] | (pb[3] & gb[2]) | (pb[3] & pb[2] & gb[1])
		| (pb[3] & pb[2] & pb[1] & gb[0]);
	assign gp.p = &pb;
endmodule

// >>> rtl/lookahead_gen.sv
// four-group carry lookahead generator
// assumes active-high generate/propagate terms; purely combinational
`timescale 1ns/1ps
module lookahead_gen
	import alu_acc_pkg::*;
(
	input  wire alu_acc_pkg::gp_t [3:0] gp_in,    // slice group terms
	input  wire logic                   cin,      // block carry in
	output logic [2:0]                  carry_mid, // carries into slices 1..3
	output alu_acc_pkg::gp_t            gp_out    // next-level group terms
);
	// standard lookahead equations, expanded so no carry ripples inside
	assign carry_mid[0] = gp_in[0].g | (gp_in[0].p & cin);
	assign carry_mid[1] = gp_in[1].g | (gp_in[1].p & gp_in[0].g)
		| (gp_in[1].p & gp_in[0].p & cin);
	assign carry_mid[2] = gp_in[2].g | (gp_in[2].p & gp_in[1].g)
		| (gp_in[2].p & gp_in[1].p & gp_in[0].g)
		| (gp_in[2].p & gp_in[1].p & gp_in[0].p & cin);
	// next-level terms allow a further level of lookahead above this one
	assign gp_out.g = gp_in[3].g | (gp_in[3].p & gp_in[2].g)
		| (gp_in[3].p & gp_in[2].p & gp_in[1].g)
		| (gp_in[3].p & gp_in[2].p & gp_in[1].p & gp_in[0].g);
	assign gp_out.p = &{gp_in[3].p, gp_in[2].p, gp_in[1].p, gp_in[0].p};
endmodule

// >>> sim/alu_acc_checker.sv
// checker: port-level assertions for the alu / accumulator top
// assumes one apb master and the bind at the foot of this file
`timescale 1ns/1ps
module alu_acc_checker
	import alu_acc_pkg::*;
#(
	parameter int WIDTH = alu_acc_pkg::WORD_W   // operand width of the bound top
)
(
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [7:0]       paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             accumulator_clear_n,
	input wire logic             shift_in_right,
	input wire logic             shift_in_left,
	input wire logic [ACC_W-1:0] acc_q,
	input wire logic             equal_flag,
	input wire logic             carry_flag
);
	logic [1:0] mode_r;  // accumulator mode the design acts on
	logic       rot_r;   // rotate rather than shift
	wire        done_w = psel && penable && pready;             // transfer completes
	wire        acc_wr = done_w && pwrite && paddr == OFS_ACC;  // acc control write lands
	wire        rd_w   = done_w && !pwrite;                     // read data taken
	wire        map_w  = paddr <= OFS_ACC && paddr[1:0] == 2'b00;  // decoded offsets
	wire        run_w  = !acc_wr && accumulator_clear_n;        // free-running edge

	// mirror the mode; it only changes when a write to acc control lands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r <= 2'b00;
			rot_r  <= 1'b0;
		end
		else if (acc_wr)
		begin
			mode_r <= pwdata[1:0];
			rot_r  <= pwdata[3];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence

	ready_wait_a: assert property (setup_s |=> access_s)
		else $error("ready not in first access cycle");
	slave_err_a: assert property (done_w |-> pslverr == !map_w)
		else $error("error response wrong for address");
	equal_read_a: assert property (
		rd_w && paddr == OFS_RESULT |-> equal_flag == &prdata[WIDTH-1:0])
		else $error("equal flag does not match result");
	flag_read_a: assert property (
		rd_w && paddr == OFS_FLAGS |-> prdata[1:0] == {carry_flag, equal_flag})
		else $error("flags register differs from pins");
	acc_clear_a: assert property (!accumulator_clear_n |-> acc_q == 8'h00)
		else $error("accumulator not cleared");
	acc_load_a: assert property (
		acc_wr && pwdata[1:0] == 2'b11 && !pwdata[4] && accumulator_clear_n
		##1 accumulator_clear_n
		|-> acc_q == ($past(pwdata[7:0]) ^ {8{$past(pwdata[2])}}))
		else $error("parallel load wrong");
	shift_left_a: assert property (
		mode_r == 2'b01 && run_w ##1 accumulator_clear_n
		|-> acc_q == {$past(acc_q[6:0]), rot_r ? $past(acc_q[7]) : $past(shift_in_left)})
		else $error("left shift wrong");
	shift_right_a: assert property (
		mode_r == 2'b10 && run_w ##1 accumulator_clear_n
		|-> acc_q == {rot_r ? $past(acc_q[0]) : $past(shift_in_right), $past(acc_q[7:1])})
		else $error("right shift wrong");
	acc_hold_a: assert property (
		mode_r == 2'b00 && run_w ##1 accumulator_clear_n |-> $stable(acc_q))
		else $error("accumulator moved in hold");
endmodule

bind alu_accumulator alu_acc_checker #(.WIDTH(WIDTH)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.accumulator_clear_n(accumulator_clear_n), .shift_in_right(shift_in_right),
	.shift_in_left(shift_in_left), .acc_q(acc_q), .equal_flag(equal_flag),
	.carry_flag(carry_flag));

// >>> sim/ctl_sequencer.sv
// partner: the controlling sequencer, an apb master issuing single transfers
// assumes the bench calls xfer and the block answers with pready
`timescale 1ns/1ps
module ctl_sequencer
(
	input wire logic        pclk,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [7:0]      paddr,
	output logic [31:0]     pwdata
);
	// idle bus at time zero
	initial
	begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
	end

	// setup, then access held until pready is high at a rising edge; pready,
	// read data and error are taken at that edge before the design's updates
	// there land, and only then is the request released
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic hung);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		hung = (pready !== 1'b1);
		q    = prdata;
		err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// released lines stop showing the old value
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask
endmodule

// >>> sim/tb_top.sv
// bench: drives the alu / accumulator top through the sequencer model
// assumes the default WIDTH of 32 and one 100 MHz clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	import alu_acc_pkg::*;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             accumulator_clear_n = 1'b0;  // held with reset so acc starts known
	logic             shift_in_right = 1'b0;
	logic             shift_in_left = 1'b0;
	logic             psel, penable, pwrite, pready, pslverr, equal_flag, carry_flag;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rdv;  // rdv: last read data
	logic [ACC_W-1:0] acc_q;
	logic             rerr;                 // last error response
	int               fail_count = 0;
	int               comparisons = 0;

	always #5 pclk = ~pclk;

	alu_accumulator dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .accumulator_clear_n(accumulator_clear_n),
		.shift_in_right(shift_in_right), .shift_in_left(shift_in_left), .acc_q(acc_q),
		.equal_flag(equal_flag), .carry_flag(carry_flag));
	ctl_sequencer seq_u (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one bus transfer; a hung slave ends the run
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic hung;
		seq_u.xfer(wr, a, d, rdv, rerr, hung);
		if (hung)
		begin
			fail_count++;
			final_report();
		end
	endtask

	function automatic logic [31:0] ctl(input logic [3:0] s, input logic ar, ci, ap, rp);
		return {24'h00_0000, rp, ap, ci, ar, s};
	endfunction

	// operands, control, then result and flags read back
	task automatic op(input logic [31:0] c, a, b, r, input logic ck, cy);
		xfer(1'b1, OFS_OPA, a);
		xfer(1'b1, OFS_OPB, b);
		xfer(1'b1, OFS_CTRL, c);
		xfer(1'b0, OFS_RESULT, 32'h0);
		`CHK("result", r, rdv)
		`CHK("equal pin", &r, equal_flag)
		xfer(1'b0, OFS_FLAGS, 32'h0);
		`CHK("equal bit", &r, rdv[0])
		if (ck)
			`CHK("carry", cy, rdv[1])
	endtask

	task automatic t_reset();
		`CHK("acc after reset", 8'h00, acc_q)
		xfer(1'b0, OFS_CTRL, 32'h0);
		`CHK("ctrl reset", CTRL_RESET, rdv)
		xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
		`CHK("unmapped write err", 1'b1, rerr)
		xfer(1'b0, 8'h18, 32'h0);
		`CHK("unmapped read err", 1'b1, rerr)
		`CHK("unmapped read data", 32'h0, rdv)
		$display("test reset done");
	endtask

	// carries across slices and blocks, lookahead and ripple wiring alike
	task automatic t_add();
		logic [31:0] tv [4][3] = '{'{32'h1234_5678, 32'h1111_1111, 32'h2345_6789},
			'{32'hFFFF_0000, 32'h0000_FFFF, 32'hFFFF_FFFF},
			'{32'h0000_FFFF, 32'h0000_0001, 32'h0001_0000},
			'{32'h0FFF_FFFF, 32'h0000_0001, 32'h1000_0000}};
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 4; i++)
				op(ctl(4'h9, 1'b1, 1'b0, 1'b0, p[0]), tv[i][0], tv[i][1], tv[i][2], 1'b0, 1'b0);
		op(ctl(4'h9, 1'b1, 1'b1, 1'b0, 1'b0), 32'h0000_FFFF, 32'h0, 32'h0001_0000, 1'b0, 1'b0);
		$display("test add done");
	endtask

	// magnitude order from carry: cin high is a minus b, low is a minus b minus 1
	task automatic t_sub();
		logic [31:0] sv [7][3] = '{'{32'h5, 32'h7, 32'hFFFF_FFFE}, '{32'h7, 32'h5, 32'h2},
			'{32'h5, 32'h5, 32'h0}, '{32'h8000_0000, 32'h7FFF_FFFF, 32'h1},
			'{32'h5, 32'h5, 32'hFFFF_FFFF}, '{32'h6, 32'h5, 32'h0}, '{32'h5, 32'h6, 32'hFFFF_FFFE}};
		logic [1:0] sf [7] = '{2'b11, 2'b10, 2'b10, 2'b10, 2'b01, 2'b00, 2'b01};
		for (int i = 0; i < 7; i++)
			op(ctl(4'h6, 1'b1, sf[i][1], 1'b0, 1'b0), sv[i][0], sv[i][1], sv[i][2], 1'b1, sf[i][0]);
		$display("test sub done");
	endtask

	// equality flag per logic function: zero operand, identical, complementary
	task automatic t_flags();
		logic [31:0] fv [4][3] = '{'{32'h0, 32'h1234_5678, 32'hFFFF_FFFF},
			'{32'h1234_5678, 32'h1234_5678, 32'hFFFF_FFFF},
			'{32'h1234_5678, 32'hEDCB_A987, 32'hFFFF_FFFF},
			'{32'h1234_5678, 32'h1234_5678, 32'h0}};
		logic [3:0] fs [4] = '{4'h0, 4'h9, 4'h6, 4'h6};
		for (int i = 0; i < 4; i++)
			op(ctl(fs[i], 1'b0, 1'b0, 1'b0, 1'b0), fv[i][0], fv[i][1], fv[i][2], 1'b0, 1'b0);
		$display("test flags done");
	endtask

	// one control line picks add or pass, the other select bits low
	task automatic t_addpass();
		op(ctl(4'h0, 1'b1, 1'b0, 1'b1, 1'b0), 32'h0F0F_0F0F, 32'h0101_0101, 32'h1010_1010, 1'b0, 1'b0);
		op(ctl(4'h0, 1'b0, 1'b0, 1'b1, 1'b0), 32'h0F0F_0F0F, 32'h0101_0101, 32'h0F0F_0F0F, 1'b0, 1'b0);
		$display("test add or pass done");
	endtask

	task automatic t_acc();
		logic [7:0] snap;
		xfer(1'b1, OFS_ACC, 32'h13);
		#1 `CHK("load from result", 8'h0F, acc_q)
		@(posedge pclk);
		shift_in_left <= 1'b1;
		xfer(1'b1, OFS_ACC, 32'hE3);
		#1 `CHK("load", 8'hE3, acc_q)
		xfer(1'b1, OFS_ACC, 32'h01);
		@(posedge pclk);
		#1 `CHK("shift left", 8'hC7, acc_q)
		@(posedge pclk);
		accumulator_clear_n <= 1'b0;
		#1 `CHK("async clear", 8'h00, acc_q)
		@(posedge pclk);
		accumulator_clear_n <= 1'b1;
		xfer(1'b1, OFS_ACC, 32'h47);
		#1 `CHK("complement load", 8'hB8, acc_q)
		xfer(1'b0, OFS_ACC, 32'h0);
		`CHK("acc readback", 8'hB8, rdv[15:8])
		xfer(1'b1, OFS_ACC, 32'h0A);
		@(posedge pclk);
		#1 `CHK("rotate right", 8'h5C, acc_q)
		xfer(1'b1, OFS_ACC, 32'h00);
		#1 snap = acc_q;
		repeat (4) @(posedge pclk);
		#1 `CHK("hold", snap, acc_q)
		$display("test accumulator done");
	endtask

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		accumulator_clear_n <= 1'b1;
		t_reset();
		t_add();
		t_sub();
		t_flags();
		t_addpass();
		t_acc();
		final_report();
	end
endmodule
